// ### fsm_pkg.sv
package fsm_pkg;
	// ----------------------------------------
	// Slave states
	// ----------------------------------------
	typedef enum logic [2:0] {
		FSM_INIT,
		FSM_PREOP,
		FSM_SAFEOP,
		FSM_OP,
		FSM_BOOT
	} fsm_state_t;

	// ----------------------------------------
	// Requested state codes
	// ----------------------------------------
	localparam logic [2:0] REQ_INIT = 3'h1;
	localparam logic [2:0] REQ_PREOP = 3'h2;
	localparam logic [2:0] REQ_BOOT = 3'h3;
	localparam logic [2:0] REQ_SAFEOP = 3'h4;
	localparam logic [2:0] REQ_OP = 3'h6;

	// ----------------------------------------
	// Mailbox protocol codes
	// ----------------------------------------
	localparam logic [3:0] MBX_FILE = 4'h4;

	// ----------------------------------------
	// Parameter addressing
	// ----------------------------------------
	localparam int PAR_IDX_W = 16;
	localparam int PAR_SUB_W = 8;
	localparam int PAR_DATA_W = 32;
	localparam int PAR_ADDR_W = 8;
	localparam logic [15:0] PAR_CHAN_STEP = 16'h0010;
	localparam logic [7:0] PAR_SUB_MAX = 8'hff;

	// ----------------------------------------
	// Timing and sizes
	// ----------------------------------------
	localparam int FIFO_DEPTH = 16;
	localparam int NV_WRITE_NS = 100;
	localparam int CLK_PERIOD_NS = 5;
	localparam int NV_WRITE_CYC = (NV_WRITE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [PAR_DATA_W-1:0] PAR_RESET_VAL = 32'h0000_0000;
endpackage : fsm_pkg

// ### fsm_fifo.sv
module fsm_fifo #(
	parameter int WIDTH = 56,
	parameter int DEPTH = 16
) (
	input wire logic i_core_clk,
	input wire logic i_nrst,
	input wire logic i_valid,
	output logic o_ready,
	input wire logic [WIDTH-1:0] i_data,
	output logic o_valid,
	input wire logic i_ready,
	output logic [WIDTH-1:0] o_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wp_reg, wp_next, rp_reg, rp_next;
	logic [AW:0] cnt_reg, cnt_next;
	logic push, pop;

	// ----------------------------------------
	// Pointers
	// ----------------------------------------
	always_comb begin
		push = i_valid && o_ready;
		pop = o_valid && i_ready;
		wp_next = push ? wp_reg + 1'b1 : wp_reg;
		rp_next = pop ? rp_reg + 1'b1 : rp_reg;
		cnt_next = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
	end

	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			wp_reg <= '0;
			rp_reg <= '0;
			cnt_reg <= '0;
		end else begin
			wp_reg <= wp_next;
			rp_reg <= rp_next;
			cnt_reg <= cnt_next;
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (push) begin
			mem[wp_reg] <= i_data;
		end
	end

	assign o_ready = cnt_reg != (AW+1)'(DEPTH);
	assign o_valid = cnt_reg != '0;
	assign o_data = mem[rp_reg];

	// Count past depth would mean a write overran the queue
	AST_FIFO_BOUND: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
		cnt_reg <= (AW+1)'(DEPTH))
		else $error("store queue overflow");
endmodule : fsm_fifo

// ### fsm_slave.sv
// Behaviour
// - Power-on enters Init; mailbox and process data refused there.
// - Init to Pre-Op needs a correct mailbox configuration.
// - Pre-Op serves mailbox, exchanges no process data.
// - Pre-Op to Safe-Op checks process data and clock settings.
// - Inputs copied to dual-port memory on the same edge that registers the Safe-Op acknowledge.
// - Safe-Op: mailbox, process data, cyclic inputs, outputs held safe.
// - Op drives physical outputs from received output data.
// - Boot reachable only from Init; Boot requests outside Init and Boot rejected.
// - Boot accepts only file access mailbox, no process data.
// - Op is the normal resting state after bootup.
// - Startup writes applied even when value is identical.
// - Parameter writes go straight into the live directory.
// - Every parameter change is stored to nonvolatile memory.
// - Local controller answers directory reads and writes.
// - Directory available from Pre-Op onward, not in Init.
// - Index plus subindex; channel blocks step 16 indices, 255 subs; the directory stores only sub[3:0], 16 subs per block.
module fsm_slave #(
	parameter int IO_W = 8,
	parameter int DIR_DEPTH = 256
) (
	input wire logic i_core_clk,
	input wire logic i_nrst,
	input wire logic i_req_valid,
	input wire logic [2:0] i_req_state,
	input wire logic i_mbx_cfg_ok,
	input wire logic i_pd_cfg_ok,
	input wire logic i_dc_cfg_ok,
	input wire logic [IO_W-1:0] i_inputs,
	input wire logic [IO_W-1:0] i_rx_outputs,
	input wire logic [IO_W-1:0] i_safe_outputs,
	input wire logic i_mbx_valid,
	input wire logic [3:0] i_mbx_proto,
	input wire logic i_pd_valid,
	input wire logic i_par_wr,
	input wire logic i_par_rd,
	output logic o_par_ready,
	input wire logic [fsm_pkg::PAR_IDX_W-1:0] i_par_idx,
	input wire logic [fsm_pkg::PAR_SUB_W-1:0] i_par_sub,
	input wire logic [fsm_pkg::PAR_DATA_W-1:0] i_par_wdata,
	output logic o_par_rvalid,
	output logic [fsm_pkg::PAR_DATA_W-1:0] o_par_rdata,
	output logic o_par_err,
	input wire logic i_nv_ready,
	output logic o_nv_valid,
	output logic [fsm_pkg::PAR_IDX_W+fsm_pkg::PAR_SUB_W+fsm_pkg::PAR_DATA_W-1:0] o_nv_data,
	output logic [2:0] o_state,
	output logic o_ack,
	output logic o_refused,
	output logic o_mbx_accept,
	output logic o_mbx_reject,
	output logic o_pd_accept,
	output logic o_pd_reject,
	output logic [IO_W-1:0] o_dpram_inputs,
	output logic [IO_W-1:0] o_phys_outputs
);
	localparam int NVW = fsm_pkg::PAR_IDX_W + fsm_pkg::PAR_SUB_W + fsm_pkg::PAR_DATA_W;
	localparam int AW = fsm_pkg::PAR_ADDR_W;

	fsm_pkg::fsm_state_t st_reg, st_next;
	logic ack_reg, ack_next, ref_reg, ref_next;
	logic mbx_acc_reg, mbx_acc_next, mbx_rej_reg, mbx_rej_next;
	logic pd_acc_reg, pd_acc_next, pd_rej_reg, pd_rej_next;
	logic [IO_W-1:0] dp_reg, dp_next, out_reg, out_next;
	logic [fsm_pkg::PAR_DATA_W-1:0] dir [DIR_DEPTH];
	logic [fsm_pkg::PAR_DATA_W-1:0] rd_reg, rd_next;
	logic rv_reg, rv_next, err_reg, err_next;
	logic [AW-1:0] dir_addr;
	logic dir_open, wr_ok, fifo_in_ready, fifo_out_valid;
	logic [NVW-1:0] fifo_out_data;
	logic nv_v_reg, nv_v_next;
	logic [NVW-1:0] nv_d_reg, nv_d_next;
	logic [2:0] cfg_m1, cfg_m2, cfg_m3;
	logic cfg_mbx, cfg_pd, cfg_dc;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	// Channel block and subindex fold to a small directory address
	function automatic logic [AW-1:0] dir_map(input logic [15:0] idx, input logic [7:0] sub);
		logic [3:0] chan;
		chan = 4'((idx / fsm_pkg::PAR_CHAN_STEP) & 16'h000f);
		dir_map = {chan, sub[3:0]};
	endfunction : dir_map

	// ----------------------------------------
	// Config pin synchronisers
	// ----------------------------------------
	// Config flags come from pins; accept once stages two and three agree
	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			cfg_m1 <= 3'h0;
			cfg_m2 <= 3'h0;
			cfg_m3 <= 3'h0;
			cfg_mbx <= 1'b0;
			cfg_pd <= 1'b0;
			cfg_dc <= 1'b0;
		end else begin
			cfg_m1 <= {i_mbx_cfg_ok, i_pd_cfg_ok, i_dc_cfg_ok};
			cfg_m2 <= cfg_m1;
			cfg_m3 <= cfg_m2;
			if (cfg_m2[2] == cfg_m3[2]) cfg_mbx <= cfg_m3[2];
			if (cfg_m2[1] == cfg_m3[1]) cfg_pd <= cfg_m3[1];
			if (cfg_m2[0] == cfg_m3[0]) cfg_dc <= cfg_m3[0];
		end
	end

	// ----------------------------------------
	// State machine
	// ----------------------------------------
	always_comb begin
		st_next = st_reg;
		ack_next = 1'b0;
		ref_next = 1'b0;
		dp_next = dp_reg;
		if (i_req_valid) begin
			unique case (i_req_state)
				fsm_pkg::REQ_INIT: begin
					st_next = fsm_pkg::FSM_INIT;
					ack_next = 1'b1;
				end
				fsm_pkg::REQ_PREOP: begin
					if ((st_reg == fsm_pkg::FSM_INIT && cfg_mbx) ||
							st_reg == fsm_pkg::FSM_SAFEOP || st_reg == fsm_pkg::FSM_OP ||
							st_reg == fsm_pkg::FSM_PREOP) begin
						st_next = fsm_pkg::FSM_PREOP;
						ack_next = 1'b1;
					end else begin
						ref_next = 1'b1;
					end
				end
				fsm_pkg::REQ_SAFEOP: begin
					if ((st_reg == fsm_pkg::FSM_PREOP && cfg_pd && cfg_dc) ||
							st_reg == fsm_pkg::FSM_OP || st_reg == fsm_pkg::FSM_SAFEOP) begin
						st_next = fsm_pkg::FSM_SAFEOP;
						ack_next = 1'b1;
						if (st_reg == fsm_pkg::FSM_PREOP) dp_next = i_inputs;
					end else begin
						ref_next = 1'b1;
					end
				end
				fsm_pkg::REQ_OP: begin
					if (st_reg == fsm_pkg::FSM_SAFEOP || st_reg == fsm_pkg::FSM_OP) begin
						st_next = fsm_pkg::FSM_OP;
						ack_next = 1'b1;
					end else begin
						ref_next = 1'b1;
					end
				end
				fsm_pkg::REQ_BOOT: begin
					if (st_reg == fsm_pkg::FSM_INIT || st_reg == fsm_pkg::FSM_BOOT) begin
						st_next = fsm_pkg::FSM_BOOT;
						ack_next = 1'b1;
					end else begin
						ref_next = 1'b1;
					end
				end
				default: begin
					ref_next = 1'b1;
				end
			endcase
		end
		if (st_reg == fsm_pkg::FSM_SAFEOP || st_reg == fsm_pkg::FSM_OP) begin
			dp_next = i_inputs;
		end
		// Outputs follow next state so leaving Op is safe on the very next edge
		out_next = (st_next == fsm_pkg::FSM_OP) ? i_rx_outputs : i_safe_outputs;
	end

	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			st_reg <= fsm_pkg::FSM_INIT;
			ack_reg <= 1'b0;
			ref_reg <= 1'b0;
			dp_reg <= '0;
			out_reg <= '0;
		end else begin
			st_reg <= st_next;
			ack_reg <= ack_next;
			ref_reg <= ref_next;
			dp_reg <= dp_next;
			out_reg <= out_next;
		end
	end

	// ----------------------------------------
	// Traffic gating
	// ----------------------------------------
	always_comb begin
		mbx_acc_next = 1'b0;
		mbx_rej_next = 1'b0;
		pd_acc_next = 1'b0;
		pd_rej_next = 1'b0;
		if (i_mbx_valid) begin
			unique case (st_reg)
				fsm_pkg::FSM_INIT: mbx_rej_next = 1'b1;
				fsm_pkg::FSM_BOOT: begin
					mbx_acc_next = i_mbx_proto == fsm_pkg::MBX_FILE;
					mbx_rej_next = i_mbx_proto != fsm_pkg::MBX_FILE;
				end
				fsm_pkg::FSM_PREOP, fsm_pkg::FSM_SAFEOP, fsm_pkg::FSM_OP: begin
					mbx_acc_next = 1'b1;
				end
			endcase
		end
		if (i_pd_valid) begin
			pd_acc_next = st_reg == fsm_pkg::FSM_SAFEOP || st_reg == fsm_pkg::FSM_OP;
			pd_rej_next = !pd_acc_next;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			mbx_acc_reg <= 1'b0;
			mbx_rej_reg <= 1'b0;
			pd_acc_reg <= 1'b0;
			pd_rej_reg <= 1'b0;
		end else begin
			mbx_acc_reg <= mbx_acc_next;
			mbx_rej_reg <= mbx_rej_next;
			pd_acc_reg <= pd_acc_next;
			pd_rej_reg <= pd_rej_next;
		end
	end

	// ----------------------------------------
	// Parameter directory
	// ----------------------------------------
	// No compare with stored value: identical writes still land and persist
	always_comb begin
		dir_open = st_reg != fsm_pkg::FSM_INIT && st_reg != fsm_pkg::FSM_BOOT;
		dir_addr = dir_map(i_par_idx, i_par_sub);
		wr_ok = i_par_wr && dir_open && fifo_in_ready;
		rv_next = 1'b0;
		err_next = 1'b0;
		rd_next = rd_reg;
		if (i_par_rd) begin
			rv_next = 1'b1;
			err_next = !dir_open;
			rd_next = dir_open ? dir[dir_addr] : '0;
		end else if (i_par_wr) begin
			err_next = !dir_open;
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (wr_ok) begin
			dir[dir_addr] <= i_par_wdata;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			rv_reg <= 1'b0;
			err_reg <= 1'b0;
			rd_reg <= fsm_pkg::PAR_RESET_VAL;
		end else begin
			rv_reg <= rv_next;
			err_reg <= err_next;
			rd_reg <= rd_next;
		end
	end

	// ----------------------------------------
	// Nonvolatile store queue
	// ----------------------------------------
	// Queue absorbs bursts of unordered startup writes; full stalls the writer
	fsm_fifo #(
		.WIDTH(NVW),
		.DEPTH(fsm_pkg::FIFO_DEPTH)
	) u_nv_fifo (
		.i_core_clk(i_core_clk),
		.i_nrst(i_nrst),
		.i_valid(wr_ok),
		.o_ready(fifo_in_ready),
		.i_data({i_par_idx, i_par_sub, i_par_wdata}),
		.o_valid(fifo_out_valid),
		.i_ready(!nv_v_reg || i_nv_ready),
		.o_data(fifo_out_data)
	);

	always_comb begin
		nv_v_next = nv_v_reg;
		nv_d_next = nv_d_reg;
		if (!nv_v_reg || i_nv_ready) begin
			nv_v_next = fifo_out_valid;
			nv_d_next = fifo_out_valid ? fifo_out_data : nv_d_reg;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			nv_v_reg <= 1'b0;
			nv_d_reg <= '0;
		end else begin
			nv_v_reg <= nv_v_next;
			nv_d_reg <= nv_d_next;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign o_state = 3'(st_reg);
	assign o_ack = ack_reg;
	assign o_refused = ref_reg;
	assign o_mbx_accept = mbx_acc_reg;
	assign o_mbx_reject = mbx_rej_reg;
	assign o_pd_accept = pd_acc_reg;
	assign o_pd_reject = pd_rej_reg;
	assign o_dpram_inputs = dp_reg;
	assign o_phys_outputs = out_reg;
	assign o_par_ready = fifo_in_ready;
	assign o_par_rvalid = rv_reg;
	assign o_par_rdata = rd_reg;
	assign o_par_err = err_reg;
	assign o_nv_valid = nv_v_reg;
	assign o_nv_data = nv_d_reg;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	AST_INIT_REFUSE: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
		(st_reg == fsm_pkg::FSM_INIT && i_mbx_valid) |=> (mbx_rej_reg && !mbx_acc_reg))
		else $error("mailbox taken in init");
	AST_PREOP_CFG: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
		(st_reg == fsm_pkg::FSM_INIT && $changed(st_reg) == 1'b0 && st_next == fsm_pkg::FSM_PREOP)
		|-> cfg_mbx)
		else $error("preop without mailbox config");
	AST_PREOP_NOPD: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
		(st_reg == fsm_pkg::FSM_PREOP && i_pd_valid) |=> pd_rej_reg)
		else $error("process data in preop");
	AST_SAFE_CHECK: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
		(st_reg == fsm_pkg::FSM_PREOP ##1 st_reg == fsm_pkg::FSM_SAFEOP) |-> $past(cfg_pd && cfg_dc))
		else $error("safeop without pd config");
	AST_SAFE_OUT: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
		(st_reg == fsm_pkg::FSM_SAFEOP) |-> (out_reg == $past(i_safe_outputs)))
		else $error("outputs driven in safeop");
	AST_OP_DRIVE: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
		(st_reg == fsm_pkg::FSM_OP) |-> (out_reg == $past(i_rx_outputs)))
		else $error("outputs not driven in op");
	AST_BOOT_ENTRY: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
		(st_reg != fsm_pkg::FSM_BOOT ##1 st_reg == fsm_pkg::FSM_BOOT) |-> $past(st_reg) == fsm_pkg::FSM_INIT)
		else $error("boot from wrong state");
	AST_BOOT_PD: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
		(st_reg == fsm_pkg::FSM_BOOT && i_pd_valid) |=> (pd_rej_reg && !pd_acc_reg))
		else $error("process data in boot");
	AST_OP_LEAVE: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
		(st_reg == fsm_pkg::FSM_OP ##1 st_reg != fsm_pkg::FSM_OP) |-> out_reg == $past(i_safe_outputs))
		else $error("outputs not safe after op");
	AST_REFUSE_HOLD: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
		ref_reg |-> $stable(st_reg))
		else $error("state moved on refusal");
endmodule : fsm_slave

// ### fsm_master_model.sv
module fsm_master_model (
	input wire logic i_core_clk,
	input wire logic i_par_ready,
	output logic o_req_valid,
	output logic [2:0] o_req_state,
	output logic o_mbx_valid,
	output logic [3:0] o_mbx_proto,
	output logic o_pd_valid,
	output logic o_par_wr,
	output logic o_par_rd,
	output logic [fsm_pkg::PAR_IDX_W-1:0] o_par_idx,
	output logic [fsm_pkg::PAR_SUB_W-1:0] o_par_sub,
	output logic [fsm_pkg::PAR_DATA_W-1:0] o_par_wdata
);
	timeunit 1ns;
	timeprecision 100ps;
	// ----------------------------------------
	// Master side, one-cycle request strobes
	// ----------------------------------------
	initial begin
		o_req_valid = 1'b0;
		o_req_state = 3'h0;
		o_mbx_valid = 1'b0;
		o_mbx_proto = 4'h0;
		o_pd_valid = 1'b0;
		o_par_wr = 1'b0;
		o_par_rd = 1'b0;
		o_par_idx = 16'h0000;
		o_par_sub = 8'h00;
		o_par_wdata = 32'h0000_0000;
	end

	// Kind 0 state, 1 mailbox, 2 process data, 3 write, 4 read
	task automatic send(input int k, input logic [3:0] c, input logic [15:0] idx,
			input logic [7:0] sub, input logic [31:0] d, output logic taken);
		@(posedge i_core_clk);
		#1;
		case (k)
			0: begin
				o_req_valid = 1'b1;
				o_req_state = c[2:0];
			end
			1: begin
				o_mbx_valid = 1'b1;
				o_mbx_proto = c;
			end
			2: o_pd_valid = 1'b1;
			default: begin
				o_par_wr = (k == 3);
				o_par_rd = (k != 3);
				o_par_idx = idx;
				o_par_sub = sub;
				o_par_wdata = d;
			end
		endcase
		taken = i_par_ready;
		@(posedge i_core_clk);
		#1;
		o_req_valid = 1'b0;
		o_mbx_valid = 1'b0;
		o_pd_valid = 1'b0;
		o_par_wr = 1'b0;
		o_par_rd = 1'b0;
		// Released lines show garbage, not the last value
		o_req_state = ~o_req_state;
		o_mbx_proto = ~o_mbx_proto;
		o_par_idx = ~o_par_idx;
		o_par_sub = ~o_par_sub;
		o_par_wdata = ~o_par_wdata;
	endtask : send
endmodule : fsm_master_model

// ### test_fsm_slave.sv
module test_fsm_slave;
	timeunit 1ns;
	timeprecision 100ps;
	// ----------------------------------------
	// Signals and scoreboard
	// ----------------------------------------
	logic i_core_clk = 1'b0;
	logic i_nrst = 1'b0;
	logic mbx_ok = 1'b0, pd_ok = 1'b0, dc_ok = 1'b0, nv_rdy = 1'b0, nv_hold = 1'b0;
	logic [7:0] ins = 8'h00, rx = 8'h00, safe = 8'h00;
	logic rv, mv, pv, wr_s, rd_s, prdy, rvalid, perr, nvv, ack, refu, ma, mr, pa, pr;
	logic [2:0] rs_st, st;
	logic [3:0] proto;
	logic [15:0] idx;
	logic [7:0] sub, dpr, phys;
	logic [31:0] wd, rdata, rs = 32'hed55798e;
	logic [55:0] nvd;
	logic [42:0] exp_q[$], msk_q[$];
	logic [55:0] nv_q[$];
	logic [31:0] val[4];
	int num_errors = 0, checks_done = 0, n;
	localparam logic [42:0] M_ST = {5'h1f, 38'h0};
	localparam logic [42:0] M_MP = {5'h0, 4'hf, 34'h0};
	localparam logic [42:0] M_RD = {9'h0, 2'h3, 32'hffff_ffff};

	always #2.5 i_core_clk = ~i_core_clk;

	fsm_master_model m (.i_core_clk(i_core_clk), .i_par_ready(prdy), .o_req_valid(rv),
		.o_req_state(rs_st), .o_mbx_valid(mv), .o_mbx_proto(proto), .o_pd_valid(pv),
		.o_par_wr(wr_s), .o_par_rd(rd_s), .o_par_idx(idx), .o_par_sub(sub), .o_par_wdata(wd));

	fsm_slave dut (.i_core_clk(i_core_clk), .i_nrst(i_nrst), .i_req_valid(rv),
		.i_req_state(rs_st), .i_mbx_cfg_ok(mbx_ok), .i_pd_cfg_ok(pd_ok), .i_dc_cfg_ok(dc_ok),
		.i_inputs(ins), .i_rx_outputs(rx), .i_safe_outputs(safe), .i_mbx_valid(mv),
		.i_mbx_proto(proto), .i_pd_valid(pv), .i_par_wr(wr_s), .i_par_rd(rd_s),
		.o_par_ready(prdy), .i_par_idx(idx), .i_par_sub(sub), .i_par_wdata(wd),
		.o_par_rvalid(rvalid), .o_par_rdata(rdata), .o_par_err(perr), .i_nv_ready(nv_rdy),
		.o_nv_valid(nvv), .o_nv_data(nvd), .o_state(st), .o_ack(ack), .o_refused(refu),
		.o_mbx_accept(ma), .o_mbx_reject(mr), .o_pd_accept(pa), .o_pd_reject(pr),
		.o_dpram_inputs(dpr), .o_phys_outputs(phys));

	function automatic logic [31:0] xs(input logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		return x;
	endfunction : xs

	task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] s);
		checks_done++;
		if (s !== e) begin
			$display("unexpected %s expected %h seen %h", nm, e, s);
			num_errors++;
		end
	endtask : chk

	task automatic act(input int k, input logic [3:0] c, input logic [15:0] i,
			input logic [7:0] sb, input logic [31:0] d, input logic [42:0] e,
			input logic [42:0] mk);
		logic tk;
		if (mk != 43'h0) begin
			exp_q.push_back(e);
			msk_q.push_back(mk);
		end
		m.send(k, c, i, sb, d, tk);
		// Only writes the buffer took are expected at the store
		if (k == 3 && tk === 1'b1 && mk == 43'h0) nv_q.push_back({i, sb, d});
	endtask : act

	task automatic req(input logic [2:0] c, input logic a, input logic [2:0] s);
		act(0, {1'b0, c}, 16'h0, 8'h0, 32'h0, {a, ~a, s, 38'h0}, M_ST);
	endtask : req

	task automatic mp(input int k, input logic [3:0] c, input logic [3:0] e);
		act(k, c, 16'h0, 8'h0, 32'h0, {5'h0, e, 34'h0}, M_MP);
	endtask : mp

	task automatic cyc(input int c);
		repeat (c) @(posedge i_core_clk);
		#1;
	endtask : cyc

	task automatic complete_run;
		$display("checks %0d errors %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : complete_run

	// ----------------------------------------
	// Result watchers
	// ----------------------------------------
	always @(negedge i_core_clk) begin
		if (i_nrst && (ack | refu | ma | mr | pa | pr | rvalid | perr) === 1'b1) begin
			if (exp_q.size() == 0) begin
				chk("unrequested result", 64'h0, 64'h1);
			end else begin
				chk("result", exp_q[0] & msk_q[0],
					{ack, refu, st, ma, mr, pa, pr, rvalid, perr, rdata} & msk_q[0]);
				void'(exp_q.pop_front());
				void'(msk_q.pop_front());
			end
		end
		if (i_nrst && (nvv & nv_rdy) === 1'b1) begin
			chk("nv count", 64'h1, 64'(nv_q.size() > 0));
			if (nv_q.size() > 0) chk("nv data", nv_q.pop_front(), nvd);
		end
	end

	// Store stalls at random, or fully while held
	always @(posedge i_core_clk) begin
		#1;
		rs = xs(rs);
		nv_rdy = !nv_hold && rs[0];
	end

	initial begin
		#100000;
		num_errors++;
		complete_run();
	end

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	initial begin
		cyc(3);
		i_nrst = 1'b1;
		chk("reset state", fsm_pkg::FSM_INIT, st);
		mp(1, 4'h1, 4'h4);
		mp(2, 4'h0, 4'h1);
		act(3, 4'h0, 16'h8000, 8'h01, 32'h1, {9'h0, 2'h1, 32'h0}, M_RD);
		req(fsm_pkg::REQ_BOOT, 1'b1, fsm_pkg::FSM_BOOT);
		mp(1, fsm_pkg::MBX_FILE, 4'h8);
		mp(1, 4'h3, 4'h4);
		mp(2, 4'h0, 4'h1);
		req(fsm_pkg::REQ_PREOP, 1'b0, fsm_pkg::FSM_BOOT);
		req(fsm_pkg::REQ_INIT, 1'b1, fsm_pkg::FSM_INIT);
		req(fsm_pkg::REQ_PREOP, 1'b0, fsm_pkg::FSM_INIT);
		req(3'h7, 1'b0, fsm_pkg::FSM_INIT);
		mbx_ok = 1'b1;
		cyc(5);
		req(fsm_pkg::REQ_PREOP, 1'b1, fsm_pkg::FSM_PREOP);
		req(fsm_pkg::REQ_BOOT, 1'b0, fsm_pkg::FSM_PREOP);
		req(fsm_pkg::REQ_OP, 1'b0, fsm_pkg::FSM_PREOP);
		mp(1, 4'h1, 4'h8);
		mp(2, 4'h0, 4'h1);
		// Startup writes issued out of order, then read back
		for (int k = 3; k >= 0; k--) begin
			rs = xs(rs);
			val[k] = rs;
			act(3, 4'h0, 16'(16'h8000 + k * fsm_pkg::PAR_CHAN_STEP), 8'(k), val[k], 43'h0,
				43'h0);
		end
		act(3, 4'h0, 16'h8000, 8'h00, val[0], 43'h0, 43'h0);
		for (int k = 0; k < 4; k++) begin
			act(4, 4'h0, 16'(16'h8000 + k * fsm_pkg::PAR_CHAN_STEP), 8'(k), 32'h0,
				{9'h0, 2'h2, val[k]}, M_RD);
		end
		act(4, 4'h0, 16'h8030, fsm_pkg::PAR_SUB_MAX, 32'h0, {9'h0, 2'h2, 32'h0},
			{9'h0, 2'h3, 32'h0});
		// Fill the buffer until it refuses, then drain it
		nv_hold = 1'b1;
		n = 0;
		while (prdy === 1'b1 && n < 40) begin
			act(3, 4'h0, 16'h8080, 8'(n), 32'(n), 43'h0, 43'h0);
			n++;
		end
		chk("buffer full", 64'h0, prdy);
		act(3, 4'h0, 16'h8090, 8'h00, 32'hdead_0000, 43'h0, 43'h0);
		nv_hold = 1'b0;
		n = 0;
		while (nv_q.size() > 0 && n < 1000) begin
			cyc(1);
			n++;
		end
		chk("nv drained", 64'h0, nv_q.size());
		cyc(4);
		chk("buffer drained", 64'h1, prdy);
		req(fsm_pkg::REQ_SAFEOP, 1'b0, fsm_pkg::FSM_PREOP);
		pd_ok = 1'b1;
		dc_ok = 1'b1;
		rs = xs(rs);
		ins = rs[7:0];
		rx = rs[15:8];
		safe = ~rs[15:8];
		cyc(5);
		req(fsm_pkg::REQ_SAFEOP, 1'b1, fsm_pkg::FSM_SAFEOP);
		chk("dpram inputs", ins, dpr);
		chk("outputs safe", safe, phys);
		mp(2, 4'h0, 4'h2);
		mp(1, 4'h1, 4'h8);
		ins = ~ins;
		cyc(2);
		chk("dpram cyclic", ins, dpr);
		req(fsm_pkg::REQ_OP, 1'b1, fsm_pkg::FSM_OP);
		cyc(1);
		chk("outputs driven", rx, phys);
		mp(2, 4'h0, 4'h2);
		req(fsm_pkg::REQ_SAFEOP, 1'b1, fsm_pkg::FSM_SAFEOP);
		chk("outputs back safe", safe, phys);
		cyc(5);
		// Reset mid-run must land back in Init with traffic refused
		i_nrst = 1'b0;
		cyc(2);
		i_nrst = 1'b1;
		chk("reset again", fsm_pkg::FSM_INIT, st);
		chk("outputs after reset", 64'h0, phys);
		mp(1, 4'h1, 4'h4);
		mp(2, 4'h0, 4'h1);
		act(4, 4'h0, 16'h8000, 8'h00, 32'h0, {9'h0, 2'h3, 32'h0}, M_RD);
		cyc(2);
		chk("results left", 64'h0, exp_q.size());
		complete_run();
	end
endmodule : test_fsm_slave
